// ---- shared/sew_regs.svh ----
// constants of the serial word-access eeprom block
// included by the package and by the design files; definitions only
`ifndef SEW_REGS_SVH
`define SEW_REGS_SVH

// register widths and array size
`define SEW_AW         12
`define SEW_DW         32
`define SEW_NWORDS     32
`define SEW_WORD_W     5

// address/op-code field positions (first shifted bit ends at the top)
`define SEW_CHIP_HI    11
`define SEW_CHIP_LO    8
`define SEW_WORD_HI    7
`define SEW_WORD_LO    3
`define SEW_OP_HI      2
`define SEW_OP_LO      0
`define SEW_STBY_BIT   0

// op codes as {first, second, third} shifted bit
`define SEW_OP_READ    3'h0
`define SEW_OP_WERASE  3'h2
`define SEW_OP_BERASE  3'h6
`define SEW_OP_WRITE   3'h4

// power-up value of the address register: op code reads as standby
`define SEW_ADDR_RST   12'h001
`define SEW_ERASED     32'h0000_0000
`define SEW_FIFO_DEPTH 8

`endif

// ---- shared/sew_pkg.sv ----
// types shared by the serial word-access eeprom block
// assumes sew_regs.svh is on the include path
`include "sew_regs.svh"

package sew_pkg;

  typedef enum logic [2:0] {
    SEW_CMD_STANDBY,
    SEW_CMD_READ,
    SEW_CMD_WERASE,
    SEW_CMD_BERASE,
    SEW_CMD_WRITE
  } sew_cmd_t;

  // one array action queued towards the core
  typedef struct packed {
    sew_cmd_t                 cmd;
    logic [`SEW_WORD_W-1:0]   word;
    logic [`SEW_DW-1:0]       data;
  } sew_prog_t;

  // pin levels, raw and synchronised
  typedef struct packed {
    logic       sclk;
    logic       rsel;
    logic       din;
    logic       supply;
    logic [3:0] chip_id;
  } sew_pins_t;

endpackage

// ---- hw/sew_core.sv ----
// serial word-access eeprom: 32 words of 32 bits behind a three-wire serial port
// assumes all pins are asynchronous to clk and the shift clock is far slower
//
// Contract
// - 12-bit address register, 32-bit data register
// - first four bits compared with strap pins
// - next five bits select the word
// - op codes: read, word/block erase, write, standby
// - entering data mode on read loads word
// - clock pulses shift out and recirculate data
// - driver on only for read, select low, match
// - shift on falling edge of serial clock
// - erased bits read as low
// - select high or standby code forces standby
// - array untouched while chip deselected
// - pull-down needs supply, erase/write, select low
// - control output only pulls down
// - reset presets op code to standby
`timescale 1ns/1ps
`include "sew_regs.svh"

module sew_fifo
  import sew_pkg::*;
#(
  parameter int WIDTH = `SEW_DW,
  parameter int DEPTH = `SEW_FIFO_DEPTH
)(
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  // filling side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // draining side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [PW:0] PTR_ONE = (PW+1)'(1);

  generate
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1)
    begin : g_bad_param
      $error("sew_fifo: depth must be a power of two of at least 2");
    end
  endgenerate

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW:0]                 wr;
    logic [PW:0]                 rd;
  } sew_fifo_st_t;

  sew_fifo_st_t q;
  sew_fifo_st_t d;
  logic         full;
  logic         empty;

  assign empty     = (q.wr == q.rd);
  assign full      = (q.wr[PW] != q.rd[PW]) && (q.wr[PW-1:0] == q.rd[PW-1:0]);
  assign in_ready  = !full;
  assign out_valid = !empty;
  assign out_data  = q.mem[q.rd[PW-1:0]];

  always_comb
  begin
    d = q;
    if (in_valid && !full)
    begin
      d.mem[q.wr[PW-1:0]] = in_data;
      d.wr                = q.wr + PTR_ONE;
    end
    if (out_ready && !empty)
    begin
      d.rd = q.rd + PTR_ONE;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      q <= '0;
    else
      q <= d;
  end

endmodule

module sew_core
  import sew_pkg::*;
#(
  parameter int FIFO_DEPTH = `SEW_FIFO_DEPTH
)(
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  // serial link pins
  input  wire logic             shift_clock,
  input  wire logic             register_select,
  input  wire logic             serial_addr_data_line_i,
  output logic                  serial_addr_data_line_o,
  output logic                  serial_addr_data_line_oe,
  // strap and supply pins
  input  wire logic [3:0]       chip_id,
  input  wire logic             supply_present,
  // open-drain programming-voltage control
  output logic                  prog_voltage_control_o,
  output logic                  prog_voltage_control_oe,
  // status
  output sew_cmd_t              cmd_decoded,
  output logic                  prog_stalled
);

  localparam int DW = `SEW_DW;

  typedef struct packed {
    sew_pins_t                        s1;
    sew_pins_t                        s2;
    logic                             clk_prev;
    logic                             rs_prev;
    logic [`SEW_AW-1:0]               addr;
    logic [DW-1:0]                    data;
    logic                             load;
    logic                             pend;
    sew_prog_t                        pend_req;
    logic [`SEW_NWORDS-1:0][DW-1:0]   mem;
  } sew_core_st_t;

  sew_core_st_t q;
  sew_core_st_t d;
  sew_pins_t    pins_in;
  sew_cmd_t     cmd;
  sew_prog_t    out_req;
  logic         fall;
  logic         rs_fall;
  logic         match;
  logic         active;
  logic         read_en;
  logic         prog_cmd;
  logic         in_ready;
  logic         out_valid;
  logic         out_ready;
  logic         out_fire;
  logic [`SEW_WORD_W-1:0] word;
  logic [DW-1:0]          rd_word;

  // op-code decode; standby bit wins over the rest
  function automatic sew_cmd_t sew_decode(input logic [2:0] op);
    sew_cmd_t c;
    c = SEW_CMD_STANDBY;
    if (!op[`SEW_STBY_BIT])
    begin
      case (op)
        `SEW_OP_READ:   c = SEW_CMD_READ;
        `SEW_OP_WERASE: c = SEW_CMD_WERASE;
        `SEW_OP_BERASE: c = SEW_CMD_BERASE;
        `SEW_OP_WRITE:  c = SEW_CMD_WRITE;
        default:        c = SEW_CMD_STANDBY;
      endcase
    end
    return c;
  endfunction

  assign pins_in = '{sclk:    shift_clock,
                     rsel:    register_select,
                     din:     serial_addr_data_line_i,
                     supply:  supply_present,
                     chip_id: chip_id};

  assign fall     = q.clk_prev && !q.s2.sclk;
  assign rs_fall  = q.rs_prev && !q.s2.rsel;
  assign match    = (q.addr[`SEW_CHIP_HI:`SEW_CHIP_LO] == q.s2.chip_id);
  assign word     = q.addr[`SEW_WORD_HI:`SEW_WORD_LO];
  assign cmd      = sew_decode(q.addr[`SEW_OP_HI:`SEW_OP_LO]);
  // select high gates active, not the decoder; standby code needs no help
  assign active   = !q.s2.rsel && match && (cmd != SEW_CMD_STANDBY);
  assign read_en  = active && (cmd == SEW_CMD_READ);
  assign prog_cmd = (cmd == SEW_CMD_WERASE) || (cmd == SEW_CMD_BERASE)
                    || (cmd == SEW_CMD_WRITE);
  assign rd_word  = q.mem[word];

  // the array port serves the read load first; queued actions wait
  assign out_ready = !q.load && !(rs_fall && read_en);
  assign out_fire  = out_valid && out_ready;

  sew_fifo #(
    .WIDTH ($bits(sew_prog_t)),
    .DEPTH (FIFO_DEPTH)
  ) i_sew_fifo (
    .clk       (clk),
    .rst       (rst),
    .in_valid  (q.pend),
    .in_ready  (in_ready),
    .in_data   (q.pend_req),
    .out_valid (out_valid),
    .out_ready (out_ready),
    .out_data  (out_req)
  );

  always_comb
  begin
    d          = q;
    d.s1       = pins_in;
    d.s2       = q.s1;
    d.clk_prev = q.s2.sclk;
    d.rs_prev  = q.s2.rsel;

    if (fall)
    begin
      d.load = 1'b0;
      if (q.s2.rsel)
        d.addr = {q.addr[`SEW_AW-2:0], q.s2.din};
      else if (read_en)
        d.data = {q.data[DW-2:0], q.data[DW-1]};
      else
        d.data = {q.data[DW-2:0], q.s2.din};
    end
    else if ((rs_fall || q.load) && read_en)
    begin
      // parallel load holds until the first clock pulse
      d.load = 1'b1;
      d.data = rd_word;
    end
    else if (!read_en)
    begin
      d.load = 1'b0;
    end

    // a queued action leaves when the fifo takes it; a new one wins
    if (q.pend && in_ready)
      d.pend = 1'b0;
    if (rs_fall && active && prog_cmd)
    begin
      d.pend          = 1'b1;
      d.pend_req.cmd  = cmd;
      d.pend_req.word = word;
      d.pend_req.data = q.data;
    end

    if (out_fire)
    begin
      case (out_req.cmd)
        SEW_CMD_BERASE:
        begin
          for (int i = 0; i < `SEW_NWORDS; i++)
            d.mem[i] = `SEW_ERASED;
        end
        SEW_CMD_WERASE: d.mem[out_req.word] = `SEW_ERASED;
        SEW_CMD_WRITE:  d.mem[out_req.word] = out_req.data;
        default:        d.mem = q.mem;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      q      <= '0;
      q.addr <= `SEW_ADDR_RST;
    end
    else
    begin
      q <= d;
    end
  end

  assign serial_addr_data_line_o  = q.data[DW-1];
  assign serial_addr_data_line_oe = read_en;
  // open drain: low level only, enable means conducting
  assign prog_voltage_control_o   = 1'b0;
  assign prog_voltage_control_oe  = q.s2.supply && active && prog_cmd;
  assign cmd_decoded              = cmd;
  assign prog_stalled             = q.pend && !in_ready;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  addr_shift_a: assert property (fall && q.s2.rsel |=>
    q.addr == {$past(q.addr[`SEW_AW-2:0]), $past(q.s2.din)})
    else $error("address register did not shift on clock fall");

  shift_edge_a: assert property (!fall |=> q.addr == $past(q.addr))
    else $error("address register moved without a clock fall");

  oe_gate_a: assert property (serial_addr_data_line_oe |->
    cmd == SEW_CMD_READ && !q.s2.rsel && match)
    else $error("data driver on outside a selected read");

  select_force_a: assert property (q.s2.rsel |->
    !serial_addr_data_line_oe && !prog_voltage_control_oe)
    else $error("select high did not force standby");

  pvc_gate_a: assert property (prog_voltage_control_oe |->
    q.s2.supply && !q.s2.rsel && match && prog_cmd)
    else $error("voltage control conducting without cause");

  pvc_pulldown_a: assert property (!prog_voltage_control_o)
    else $error("voltage control driven high");

  read_load_a: assert property (rs_fall && read_en && !fall |=>
    q.data == $past(rd_word) ##1 (q.load || $past(fall)))
    else $error("read did not load the addressed word");

  recirc_a: assert property (fall && read_en |=>
    q.data == {$past(q.data[DW-2:0]), $past(q.data[DW-1])} && !q.load)
    else $error("read data did not recirculate");

  // outside a read the data register only takes the line, never the array
  data_shift_a: assert property (fall && !q.s2.rsel && !read_en |=>
    q.data == {$past(q.data[DW-2:0]), $past(q.s2.din)})
    else $error("data register did not shift in the line bit");

  standby_code_a: assert property (q.addr[`SEW_STBY_BIT] |->
    cmd == SEW_CMD_STANDBY && !serial_addr_data_line_oe && !prog_voltage_control_oe)
    else $error("standby code did not force standby");

  word_erase_a: assert property (out_fire && out_req.cmd == SEW_CMD_WERASE
    |=> q.mem[$past(out_req.word)] == `SEW_ERASED)
    else $error("word erase left data behind");

  block_erase_a: assert property (out_fire && out_req.cmd == SEW_CMD_BERASE
    |=> q.mem[0] == `SEW_ERASED && q.mem[`SEW_NWORDS-1] == `SEW_ERASED)
    else $error("block erase left data behind");

  word_write_a: assert property (out_fire && out_req.cmd == SEW_CMD_WRITE
    |=> q.mem[$past(out_req.word)] == $past(out_req.data))
    else $error("write did not program the selected word");

  queue_cause_a: assert property ($rose(q.pend) |->
    $past(!q.s2.rsel) && $past(match) && $past(prog_cmd))
    else $error("array action queued while deselected");

  reset_stby_a: assert property ($past(rst) |-> q.addr[`SEW_STBY_BIT])
    else $error("op code not standby after reset");

endmodule

// ---- dv/sew_host.sv ----
// host controller model driving the serial link of the eeprom
// assumes clk runs at 4 ns; the shift clock period is 125 ns, off the clk grid
`timescale 1ns/1ps

module sew_host (
  // system clock
  input  wire logic clk,
  // link pins
  output logic      sclk,
  output logic      rsel,
  output logic      h_d,
  output logic      h_oe,
  input  wire logic line
);
  // half of the 125 ns link period; not a whole number of clk
  localparam realtime HALF = 62.5;

  initial
  begin
    sclk = 1'b0;
    rsel = 1'b1;
    h_d  = 1'b0;
    h_oe = 1'b0;
  end

  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk);
  endtask

  // data set at the rise, half a period before the fall that takes it
  task automatic pulse(input logic b);
    h_d  <= b;
    sclk <= 1'b1;
    #(HALF);
    sclk <= 1'b0;
    #(HALF);
  endtask

  task automatic go(input logic v, input int n);
    rsel <= v;
    wait_clk(n);
  endtask

  task automatic send_addr(input logic [11:0] a);
    h_oe <= 1'b1;
    go(1'b1, 1);
    for (int i = 11; i >= 0; i--)
      pulse(a[i]);
    // release the line so a read answer never meets the host driving it
    h_oe <= 1'b0;
  endtask

  task automatic send_data(input logic [31:0] d);
    h_oe <= 1'b1;
    for (int i = 31; i >= 0; i--)
      pulse(d[i]);
  endtask

  // released line; first bit is there before any pulse
  task automatic read(output logic [31:0] w);
    h_oe <= 1'b0;
    go(1'b0, 20);
    for (int i = 31; i >= 0; i--)
    begin
      w[i] = line;
      if (i > 0)
        pulse(1'b0);
    end
    go(1'b1, 4);
  endtask
endmodule

// ---- dv/sew_core_tb_top.sv ----
// self-checking bench of the serial eeprom core
// assumes sew_pkg and sew_regs.svh; host model in sew_host.sv
`timescale 1ns/1ps
`include "sew_regs.svh"

module sew_core_tb_top
  import sew_pkg::*;
;
  localparam logic [3:0]  CHIP = 4'ha;
  localparam logic [3:0]  OTHR = 4'h5;
  localparam logic [31:0] PAT  = 32'ha5c3_0f81;

  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        sclk, rsel, h_d, h_oe, dq_o, dq_oe, pvc_o, pvc_oe, stalled;
  logic        supply = 1'b1;
  logic        idle_t = 1'b0;
  logic [3:0]  chip_id = CHIP;
  logic [31:0] w;
  logic        seen;
  sew_cmd_t    cmd;
  int          fail_count = 0;
  int          tests_run = 0;
  wire logic   line;

  always #2 clk = ~clk;
  // an undriven line must not look like a stable level
  always @(posedge clk) idle_t <= ~idle_t;
  assign line = dq_oe ? dq_o : (h_oe ? h_d : idle_t);

  sew_core i_sew_core (
    .clk                      (clk),
    .rst                      (rst),
    .shift_clock              (sclk),
    .register_select          (rsel),
    .serial_addr_data_line_i  (line),
    .serial_addr_data_line_o  (dq_o),
    .serial_addr_data_line_oe (dq_oe),
    .chip_id                  (chip_id),
    .supply_present           (supply),
    .prog_voltage_control_o   (pvc_o),
    .prog_voltage_control_oe  (pvc_oe),
    .cmd_decoded              (cmd),
    .prog_stalled             (stalled)
  );

  sew_host i_sew_host (
    .clk  (clk),
    .sclk (sclk),
    .rsel (rsel),
    .h_d  (h_d),
    .h_oe (h_oe),
    .line (line)
  );

  task automatic chk1(input logic g, input logic e);
    tests_run++;
    if (g !== e)
    begin
      fail_count++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic chk32(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e)
    begin
      fail_count++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic chkc(input sew_cmd_t g, input sew_cmd_t e);
    chk32({29'h0, g}, {29'h0, e});
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic op(input logic [3:0] c, input logic [4:0] a, input logic [2:0] o);
    i_sew_host.send_addr({c, a, o});
    i_sew_host.go(1'b0, 20);
  endtask

  task automatic rd(input logic [3:0] c, input logic [4:0] a);
    op(c, a, `SEW_OP_READ);
    chkc(cmd, SEW_CMD_READ);
    seen = dq_oe;
    i_sew_host.read(w);
  endtask

  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    op(CHIP, a, `SEW_OP_WERASE);
    chkc(cmd, SEW_CMD_WERASE);
    chk1(pvc_oe, 1'b1);
    i_sew_host.send_data(d);
    i_sew_host.go(1'b1, 4);
    chk1(pvc_oe, 1'b0);
    op(CHIP, a, `SEW_OP_WRITE);
    chkc(cmd, SEW_CMD_WRITE);
    chk1(pvc_oe, 1'b1);
    chk1(dq_oe, 1'b0);
    i_sew_host.go(1'b1, 4);
    op(CHIP, a, 3'h7);
    chkc(cmd, SEW_CMD_STANDBY);
    chk1(pvc_oe, 1'b0);
    i_sew_host.go(1'b1, 4);
  endtask

  task automatic t_reset();
    chkc(cmd, SEW_CMD_STANDBY);
    chk1(pvc_oe, 1'b0);
    chk1(dq_oe, 1'b0);
    chk1(stalled, 1'b0);
  endtask

  task automatic t_erased();
    i_sew_host.send_addr({CHIP, 5'h05, `SEW_OP_READ});
    chk1(dq_oe, 1'b0);
    rd(CHIP, 5'h05);
    chk1(seen, 1'b1);
    chk32(w, `SEW_ERASED);
  endtask

  task automatic t_write();
    wr(5'h03, PAT);
    wr(5'h04, ~PAT);
    rd(CHIP, 5'h03);
    chk32(w, PAT);
    op(CHIP, 5'h04, `SEW_OP_WERASE);
    i_sew_host.go(1'b1, 4);
    rd(CHIP, 5'h04);
    chk32(w, `SEW_ERASED);
    rd(CHIP, 5'h03);
    chk32(w, PAT);
  endtask

  task automatic t_other();
    op(OTHR, 5'h03, `SEW_OP_WRITE);
    chk1(pvc_oe, 1'b0);
    rd(OTHR, 5'h03);
    chk1(seen, 1'b0);
    rd(CHIP, 5'h03);
    chk32(w, PAT);
    @(posedge clk);
    supply <= 1'b0;
    op(CHIP, 5'h03, `SEW_OP_WRITE);
    chk1(pvc_oe, 1'b0);
    chk1(pvc_o, 1'b0);
    i_sew_host.go(1'b1, 4);
    supply <= 1'b1;
  endtask

  task automatic t_block();
    op(CHIP, 5'h1f, `SEW_OP_BERASE);
    chkc(cmd, SEW_CMD_BERASE);
    chk1(pvc_oe, 1'b1);
    i_sew_host.go(1'b1, 40);
    chk1(stalled, 1'b0);
    rd(CHIP, 5'h03);
    chk32(w, `SEW_ERASED);
  endtask

  initial
  begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    t_reset();
    t_erased();
    t_write();
    t_other();
    t_block();
    final_report();
  end

  // whole sequence needs about 16000 clk
  initial
  begin
    repeat (90000) @(posedge clk);
    fail_count++;
    final_report();
  end
endmodule
